//--- rtl/fct_timer.sv
// Overview of operation
// - compare a interrupt requested while its flag and enable are both one.
// - compare b enable bit 2 gates the compare b flag onto its interrupt.
// - compare a flag sets on count equal to compare a; read-one then write-zero clears.
// - compare b flag, bit 2, sets when count becomes equal to compare b.
// - compare b flag clears only after read as one then write zero; one is ignored.
// - counter steps per tick, wraps to zero, sets wrap flag bit 1; read-then-zero clears.
// - clear-on-match-a bit 0, reset zero, clears the counter on compare match a.
// - compare a and b share one byte pair, chosen by a select setting.
// - compare select zero, its reset value, reaches a; one reaches b.
// - a capture event copies the current count into the read-only capture value.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "fct_cfg.svh"
module fct_timer (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire fct_pkg::fct_addr_type awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output fct_pkg::fct_resp_type bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire fct_pkg::fct_addr_type araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output fct_pkg::fct_resp_type rresp,
   output logic rvalid,
   input wire logic rready,
   // timer events
   input wire logic count_tick,
   input wire logic capture_strobe,
   // interrupts
   output logic compare_a_irq,
   output logic compare_b_irq,
   output logic wrap_irq,
   output logic capture_irq,
   output logic irq
);
   import fct_pkg::*;

   logic reg_wr, reg_rd, reg_whit, reg_rhit;
   logic [7:0] reg_widx, reg_ridx;
   fct_byte_type reg_wbyte, reg_rbyte;
   logic match_a, match_b, wrap, count_load;
   fct_word_type count, count_load_value;

   fct_byte_type irq_en_q, irq_en_d;
   fct_byte_type flags_q, flags_d;
   fct_byte_type armed_q, armed_d;
   logic clear_on_match_a_q, clear_on_match_a_d;
   logic compare_select_q, compare_select_d;
   fct_byte_type cmp_ctrl_spare_q, cmp_ctrl_spare_d;
   fct_byte_type hold_q, hold_d;
   fct_word_type compare_value_a_q, compare_value_a_d;
   fct_word_type compare_value_b_q, compare_value_b_d;
   fct_word_type capture_value_q, capture_value_d;
   logic irq_q;

   // low index byte selects the register inside the decoded window
   function automatic logic [7:0] idx_of(input logic [31:0] idx);
      return idx[7:0];
   endfunction

   function automatic logic is_mapped(input logic [7:0] i);
      case (i)
         idx_of(`FCT_IDX_IRQ_EN), idx_of(`FCT_IDX_FLAGS),
         idx_of(`FCT_IDX_COUNT_HI), idx_of(`FCT_IDX_COUNT_LO),
         idx_of(`FCT_IDX_CMP_HI), idx_of(`FCT_IDX_CMP_LO),
         idx_of(`FCT_IDX_CMP_CTRL), idx_of(`FCT_IDX_CAP_HI),
         idx_of(`FCT_IDX_CAP_LO): return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   fct_axil_slave u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_widx(reg_widx),
      .reg_ridx(reg_ridx),
      .reg_wbyte(reg_wbyte),
      .reg_rbyte(reg_rbyte),
      .reg_whit(reg_whit),
      .reg_rhit(reg_rhit)
   );

   fct_counter #(.WIDTH(16)) u_count (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(count_tick),
      .load(count_load),
      .load_value(count_load_value),
      .clear_on_a(clear_on_match_a_q),
      .cmp_a(compare_value_a_q),
      .cmp_b(compare_value_b_q),
      .count(count),
      .match_a(match_a),
      .match_b(match_b),
      .wrap(wrap)
   );

   assign reg_whit = is_mapped(reg_widx);
   assign reg_rhit = is_mapped(reg_ridx);
   // a low-byte write completes the pair with the held high byte
   assign count_load = reg_wr && reg_widx == idx_of(`FCT_IDX_COUNT_LO);
   assign count_load_value = {hold_q, reg_wbyte};

   // read data; high-byte reads also park the low byte in the holding byte
   always_comb begin
      case (reg_ridx)
         idx_of(`FCT_IDX_IRQ_EN): reg_rbyte = irq_en_q;
         idx_of(`FCT_IDX_FLAGS): reg_rbyte = flags_q | {7'h00, clear_on_match_a_q};
         idx_of(`FCT_IDX_COUNT_HI): reg_rbyte = count[15:8];
         idx_of(`FCT_IDX_CMP_HI): reg_rbyte = compare_select_q ? compare_value_b_q[15:8]
                                                               : compare_value_a_q[15:8];
         idx_of(`FCT_IDX_CAP_HI): reg_rbyte = capture_value_q[15:8];
         idx_of(`FCT_IDX_COUNT_LO), idx_of(`FCT_IDX_CMP_LO),
         idx_of(`FCT_IDX_CAP_LO): reg_rbyte = hold_q;
         idx_of(`FCT_IDX_CMP_CTRL): reg_rbyte = `FCT_CMP_CTRL_ONES | cmp_ctrl_spare_q
                                                | {3'h0, compare_select_q, 4'h0};
         default: reg_rbyte = 8'h00;
      endcase
   end

   always_comb begin
      irq_en_d = irq_en_q;
      clear_on_match_a_d = clear_on_match_a_q;
      compare_select_d = compare_select_q;
      cmp_ctrl_spare_d = cmp_ctrl_spare_q;
      hold_d = hold_q;
      compare_value_a_d = compare_value_a_q;
      compare_value_b_d = compare_value_b_q;
      capture_value_d = capture_value_q;
      armed_d = armed_q;
      flags_d = flags_q;
      if (reg_rd) begin
         case (reg_ridx)
            idx_of(`FCT_IDX_FLAGS): armed_d = armed_q | flags_q;
            idx_of(`FCT_IDX_COUNT_HI): hold_d = count[7:0];
            idx_of(`FCT_IDX_CMP_HI): hold_d = compare_select_q ? compare_value_b_q[7:0]
                                                               : compare_value_a_q[7:0];
            idx_of(`FCT_IDX_CAP_HI): hold_d = capture_value_q[7:0];
            default: hold_d = hold_q;
         endcase
      end
      if (reg_wr) begin
         case (reg_widx)
            idx_of(`FCT_IDX_IRQ_EN): irq_en_d = reg_wbyte;
            idx_of(`FCT_IDX_FLAGS): begin
               // only a zero to an armed flag clears it; a one is ignored
               flags_d = flags_q & ~(armed_q & ~reg_wbyte & `FCT_FLAG_MASK);
               armed_d = 8'h00;
               clear_on_match_a_d = reg_wbyte[`FCT_BIT_CLR_ON_A];
            end
            idx_of(`FCT_IDX_COUNT_HI), idx_of(`FCT_IDX_CMP_HI): hold_d = reg_wbyte;
            idx_of(`FCT_IDX_CMP_LO): begin
               if (compare_select_q) begin
                  compare_value_b_d = {hold_q, reg_wbyte};
               end else begin
                  compare_value_a_d = {hold_q, reg_wbyte};
               end
            end
            idx_of(`FCT_IDX_CMP_CTRL): begin
               compare_select_d = reg_wbyte[`FCT_BIT_CMP_SEL];
               cmp_ctrl_spare_d = {4'h0, reg_wbyte[3:0]};
            end
            default: flags_d = flags_q;
         endcase
      end
      // hardware set wins over a software clear in the same cycle
      if (capture_strobe) begin
         capture_value_d = count;
         flags_d[`FCT_BIT_CAPTURE] = 1'b1;
      end
      if (match_a) begin
         flags_d[`FCT_BIT_CMP_A] = 1'b1;
      end
      if (match_b) begin
         flags_d[`FCT_BIT_CMP_B] = 1'b1;
      end
      if (wrap) begin
         flags_d[`FCT_BIT_WRAP] = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_en_q <= `FCT_RST_IRQ_EN;
         flags_q <= `FCT_RST_FLAGS;
         armed_q <= 8'h00;
         clear_on_match_a_q <= 1'b0;
         compare_select_q <= 1'b0;
         cmp_ctrl_spare_q <= 8'h00;
         hold_q <= 8'h00;
         compare_value_a_q <= `FCT_RST_CMP;
         compare_value_b_q <= `FCT_RST_CMP;
         capture_value_q <= `FCT_RST_COUNT;
      end else begin
         irq_en_q <= irq_en_d;
         flags_q <= flags_d;
         armed_q <= armed_d;
         clear_on_match_a_q <= clear_on_match_a_d;
         compare_select_q <= compare_select_d;
         cmp_ctrl_spare_q <= cmp_ctrl_spare_d;
         hold_q <= hold_d;
         compare_value_a_q <= compare_value_a_d;
         compare_value_b_q <= compare_value_b_d;
         capture_value_q <= capture_value_d;
      end
   end

   // requests straight from flag and enable flip-flops
   assign compare_a_irq = flags_q[`FCT_BIT_CMP_A] && irq_en_q[`FCT_BIT_CMP_A];
   assign compare_b_irq = flags_q[`FCT_BIT_CMP_B] && irq_en_q[`FCT_BIT_CMP_B];
   assign wrap_irq = flags_q[`FCT_BIT_WRAP] && irq_en_q[`FCT_BIT_WRAP];
   assign capture_irq = flags_q[`FCT_BIT_CAPTURE] && irq_en_q[`FCT_BIT_CAPTURE];
   assign irq = |(flags_q & irq_en_q & `FCT_FLAG_MASK);
   assign irq_q = irq;

   a_cmp_a_irq: assert property (@(posedge aclk) disable iff (!aresetn)
      match_a && irq_en_q[`FCT_BIT_CMP_A] ##1 irq_en_q[`FCT_BIT_CMP_A] |-> compare_a_irq && irq_q)
      else $error("compare a match did not raise its interrupt");
   a_cmp_b_mask: assert property (@(posedge aclk) disable iff (!aresetn)
      !irq_en_q[`FCT_BIT_CMP_B] |-> !compare_b_irq)
      else $error("compare b interrupt passed a zero enable");
   a_cmp_a_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      match_a |=> flags_q[`FCT_BIT_CMP_A])
      else $error("compare a flag not set on match");
   a_cmp_b_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      match_b |=> flags_q[`FCT_BIT_CMP_B])
      else $error("compare b flag not set on match");
   a_unarmed_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
      flags_q[`FCT_BIT_CMP_B] && !armed_q[`FCT_BIT_CMP_B] |=> flags_q[`FCT_BIT_CMP_B])
      else $error("compare b flag cleared without a prior read");
   a_one_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
      flags_q[`FCT_BIT_CMP_B] && reg_wr && reg_widx == idx_of(`FCT_IDX_FLAGS)
      && reg_wbyte[`FCT_BIT_CMP_B] |=> flags_q[`FCT_BIT_CMP_B])
      else $error("writing one changed the compare b flag");
   a_wrap_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      wrap |=> flags_q[`FCT_BIT_WRAP] && count == 16'h0000)
      else $error("wrap did not set flag or reach zero");
   a_cap_copy: assert property (@(posedge aclk) disable iff (!aresetn)
      capture_strobe |=> capture_value_q == $past(count) && flags_q[`FCT_BIT_CAPTURE])
      else $error("capture did not copy the count");
   a_wrap_irq: assert property (@(posedge aclk) disable iff (!aresetn)
      wrap_irq |-> flags_q[`FCT_BIT_WRAP] && irq_en_q[`FCT_BIT_WRAP] && irq)
      else $error("wrap interrupt without flag and enable");
endmodule // fct_timer

//--- rtl/fct_cfg.svh
`ifndef FCT_CFG_SVH
`define FCT_CFG_SVH

// register indices; byte address is four times the index
`define FCT_IDX_IRQ_EN 32'hffff_fe10
`define FCT_IDX_FLAGS 32'hffff_fe11
`define FCT_IDX_COUNT_HI 32'hffff_fe12
`define FCT_IDX_COUNT_LO 32'hffff_fe13
`define FCT_IDX_CMP_HI 32'hffff_fe14
`define FCT_IDX_CMP_LO 32'hffff_fe15
`define FCT_IDX_CMP_CTRL 32'hffff_fe17
`define FCT_IDX_CAP_HI 32'hffff_fe18
`define FCT_IDX_CAP_LO 32'hffff_fe19

// bit positions; flag and enable registers share all but clear-on-match-a (flags only); compare select sits in the compare control register
`define FCT_BIT_CAPTURE 7
`define FCT_BIT_CMP_A 3
`define FCT_BIT_CMP_B 2
`define FCT_BIT_WRAP 1
`define FCT_BIT_CLR_ON_A 0
`define FCT_BIT_CMP_SEL 4
`define FCT_FLAG_MASK 8'h8e

// reset values
`define FCT_RST_IRQ_EN 8'h01
`define FCT_RST_FLAGS 8'h00
`define FCT_RST_COUNT 16'h0000
`define FCT_RST_CMP 16'hffff
`define FCT_CMP_CTRL_ONES 8'he0

// bus answers
`define FCT_RESP_OKAY 2'h0
`define FCT_RESP_SLVERR 2'h2

`endif

//--- rtl/fct_pkg.sv
package fct_pkg;
   typedef logic [7:0] fct_byte_type;
   typedef logic [15:0] fct_word_type;
   typedef logic [31:0] fct_addr_type;
   typedef logic [1:0] fct_resp_type;
endpackage

//--- rtl/fct_axil_slave.sv
`timescale 1ns/1ns
`include "fct_cfg.svh"
module fct_axil_slave (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write channels
   input wire fct_pkg::fct_addr_type awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output fct_pkg::fct_resp_type bresp,
   output logic bvalid,
   input wire logic bready,
   // read channels
   input wire fct_pkg::fct_addr_type araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output fct_pkg::fct_resp_type rresp,
   output logic rvalid,
   input wire logic rready,
   // register side
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_widx,
   output logic [7:0] reg_ridx,
   output fct_pkg::fct_byte_type reg_wbyte,
   input wire fct_pkg::fct_byte_type reg_rbyte,
   input wire logic reg_whit,
   input wire logic reg_rhit
);
   import fct_pkg::*;

   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   fct_resp_type bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;

   // address and data are taken together; the slave simply waits for both
   assign awready = awvalid && wvalid && !bvalid_q;
   assign wready = awready;
   assign arready = !rvalid_q;
   assign reg_wr = awready && wstrb[0];
   assign reg_rd = arvalid && arready;
   assign reg_widx = awaddr[9:2];
   assign reg_ridx = araddr[9:2];
   assign reg_wbyte = wdata[7:0];
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;

   always_comb begin
      bvalid_d = bvalid_q && !bready;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q && !rready;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (awready) begin
         bvalid_d = 1'b1;
         bresp_d = reg_whit ? `FCT_RESP_OKAY : `FCT_RESP_SLVERR;
      end
      if (reg_rd) begin
         rvalid_d = 1'b1;
         rresp_d = reg_rhit ? `FCT_RESP_OKAY : `FCT_RESP_SLVERR;
         rdata_d = {24'h00_0000, reg_rhit ? reg_rbyte : 8'h00};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= `FCT_RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= `FCT_RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else begin
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end
endmodule // fct_axil_slave

//--- rtl/fct_counter.sv
`timescale 1ns/1ns
`include "fct_cfg.svh"
module fct_counter #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic tick,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_value,
   input wire logic clear_on_a,
   input wire logic [WIDTH-1:0] cmp_a,
   input wire logic [WIDTH-1:0] cmp_b,
   // state and events
   output logic [WIDTH-1:0] count,
   output logic match_a,
   output logic match_b,
   output logic wrap
);
   import fct_pkg::*;

   logic [WIDTH-1:0] count_q, count_d;
   logic fresh_q, fresh_d;

   // the register map only carries two count bytes
   if (WIDTH < 2 || WIDTH > 16) begin : g_width_check
      $error("fct_counter: WIDTH must be 2 to 16");
   end

   assign count = count_q;
   // a match is flagged only when the count has just taken its new value
   assign match_a = fresh_q && (count_q == cmp_a);
   assign match_b = fresh_q && (count_q == cmp_b);
   assign wrap = tick && !load && !(clear_on_a && count_q == cmp_a) && (&count_q);

   always_comb begin
      count_d = count_q;
      fresh_d = 1'b0;
      if (load) begin
         count_d = load_value;
      end else if (tick) begin
         fresh_d = 1'b1;
         if (clear_on_a && count_q == cmp_a) begin
            count_d = '0;
         end else begin
            count_d = count_q + 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= '0;
         fresh_q <= 1'b0;
      end else begin
         count_q <= count_d;
         fresh_q <= fresh_d;
      end
   end

   a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
      tick && !load && !(clear_on_a && count_q == cmp_a) |=> count_q == $past(count_q) + 1'b1)
      else $error("counter did not step by one");
   a_clear_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
      tick && !load && clear_on_a && count_q == cmp_a |=> count_q == '0)
      else $error("counter not cleared on match a");
   a_hold_no_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !tick && !load |=> $stable(count_q) && !match_a && !match_b)
      else $error("counter moved without a tick");
endmodule // fct_counter

//--- verif/fct_cpu_model.sv
`timescale 1ns/1ns
module fct_cpu_model (
   // clock
   input wire logic aclk,
   // write channels
   output fct_pkg::fct_addr_type awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire fct_pkg::fct_resp_type bresp,
   input wire logic bvalid,
   output logic bready,
   // read channels
   output fct_pkg::fct_addr_type araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire fct_pkg::fct_resp_type rresp,
   input wire logic rvalid,
   output logic rready
);
   import fct_pkg::*;

   initial begin
      awaddr = '0;
      awvalid = 1'b0;
      wdata = '0;
      wstrb = 4'h1;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = '0;
      arvalid = 1'b0;
      rready = 1'b0;
   end

   // byte address is four times the register index
   task automatic wr(input logic [31:0] idx, input fct_byte_type d, output fct_resp_type r);
      @(posedge aclk);
      awaddr <= idx << 2;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge aclk); while (!(awready && wready));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge aclk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] idx, output fct_byte_type d, output fct_resp_type r);
      @(posedge aclk);
      araddr <= idx << 2;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      d = rdata[7:0];
      r = rresp;
      rready <= 1'b0;
   endtask

   // high byte always first, so the holding byte pairs the halves
   task automatic wr16(input logic [31:0] idx_hi, input fct_word_type w);
      fct_resp_type r;
      wr(idx_hi, w[15:8], r);
      wr(idx_hi + 32'h0000_0001, w[7:0], r);
   endtask

   task automatic rd16(input logic [31:0] idx_hi, output fct_word_type w);
      fct_resp_type r;
      rd(idx_hi, w[15:8], r);
      rd(idx_hi + 32'h0000_0001, w[7:0], r);
   endtask
endmodule // fct_cpu_model

//--- verif/tb_free_running_timer_core.sv
`timescale 1ns/1ns
`include "fct_cfg.svh"
module tb_free_running_timer_core;
   import fct_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, count_tick, capture_strobe;
   logic compare_a_irq, compare_b_irq, wrap_irq, capture_irq, irq;
   fct_addr_type awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   fct_resp_type bresp, rresp, r;
   fct_byte_type b;
   int failures;
   int num_checks;

   fct_cpu_model cpu (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   fct_timer uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .count_tick(count_tick), .capture_strobe(capture_strobe),
      .compare_a_irq(compare_a_irq), .compare_b_irq(compare_b_irq), .wrap_irq(wrap_irq),
      .capture_irq(capture_irq), .irq(irq));

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic stop_test;
      if (failures == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk_val(input string n, input fct_word_type e, input fct_word_type g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_bit(input string n, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic chk_resp(input string n, input fct_resp_type e, input fct_resp_type g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr1(input logic [31:0] idx, input fct_byte_type d);
      fct_resp_type rs;
      cpu.wr(idx, d, rs);
   endtask

   task automatic rdc(input string n, input logic [31:0] idx, input fct_byte_type e);
      fct_byte_type d;
      fct_resp_type rs;
      cpu.rd(idx, d, rs);
      chk_val(n, {8'h00, e}, {8'h00, d});
   endtask

   task automatic rdc16(input string n, input logic [31:0] idx, input fct_word_type e);
      fct_word_type w;
      cpu.rd16(idx, w);
      chk_val(n, e, w);
   endtask

   // tick held high n cycles gives exactly n count steps
   task automatic tick(input int n);
      @(posedge aclk);
      count_tick <= 1'b1;
      repeat (n) @(posedge aclk);
      count_tick <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask

   task automatic test_reset;
      rdc("enables", `FCT_IDX_IRQ_EN, 8'h01);
      rdc("flags", `FCT_IDX_FLAGS, 8'h00);
      rdc16("count", `FCT_IDX_COUNT_HI, 16'h0000);
      rdc16("compare", `FCT_IDX_CMP_HI, 16'hffff);
      rdc("cmp ctrl", `FCT_IDX_CMP_CTRL, 8'he0);
      rdc16("capture", `FCT_IDX_CAP_HI, 16'h0000);
      cpu.rd(32'hffff_fe16, b, r);
      chk_resp("unmapped read", `FCT_RESP_SLVERR, r);
      chk_val("unmapped data", 16'h0000, {8'h00, b});
      cpu.wr(32'hffff_fe16, 8'h55, r);
      chk_resp("unmapped write", `FCT_RESP_SLVERR, r);
      chk_bit("irq idle", 1'b0, irq);
      // a write without its low byte lane must leave the register alone
      cpu.wstrb <= 4'h0;
      wr1(`FCT_IDX_IRQ_EN, 8'hff);
      cpu.wstrb <= 4'h1;
      rdc("strobe off", `FCT_IDX_IRQ_EN, 8'h01);
   endtask

   task automatic test_match_a;
      cpu.wr16(`FCT_IDX_CMP_HI, 16'h0010);
      wr1(`FCT_IDX_IRQ_EN, 8'h08);
      tick(15);
      rdc("flags early", `FCT_IDX_FLAGS, 8'h00);
      chk_bit("a irq early", 1'b0, compare_a_irq);
      tick(1);
      chk_bit("a irq", 1'b1, compare_a_irq);
      chk_bit("irq", 1'b1, irq);
      rdc16("count", `FCT_IDX_COUNT_HI, 16'h0010);
      rdc("flags a", `FCT_IDX_FLAGS, 8'h08);
      wr1(`FCT_IDX_FLAGS, 8'h00);
      rdc("flags a clear", `FCT_IDX_FLAGS, 8'h00);
      chk_bit("a irq clear", 1'b0, compare_a_irq);
   endtask

   task automatic test_match_b;
      wr1(`FCT_IDX_CMP_CTRL, 8'h10);
      cpu.wr16(`FCT_IDX_CMP_HI, 16'h0020);
      rdc16("cmp b", `FCT_IDX_CMP_HI, 16'h0020);
      wr1(`FCT_IDX_CMP_CTRL, 8'h00);
      rdc16("cmp a kept", `FCT_IDX_CMP_HI, 16'h0010);
      wr1(`FCT_IDX_IRQ_EN, 8'h04);
      tick(16);
      chk_bit("b irq", 1'b1, compare_b_irq);
      chk_bit("a irq off", 1'b0, compare_a_irq);
      wr1(`FCT_IDX_IRQ_EN, 8'h00);
      chk_bit("b irq masked", 1'b0, compare_b_irq);
      // zero written without a prior read must not clear
      wr1(`FCT_IDX_FLAGS, 8'h00);
      rdc("flags b", `FCT_IDX_FLAGS, 8'h04);
      wr1(`FCT_IDX_FLAGS, 8'h04);
      rdc("flags b one", `FCT_IDX_FLAGS, 8'h04);
      wr1(`FCT_IDX_FLAGS, 8'h00);
      rdc("flags b clear", `FCT_IDX_FLAGS, 8'h00);
   endtask

   task automatic test_wrap;
      wr1(`FCT_IDX_IRQ_EN, 8'h02);
      cpu.wr16(`FCT_IDX_COUNT_HI, 16'hfffe);
      tick(1);
      rdc("no wrap at max", `FCT_IDX_FLAGS, 8'h00);
      tick(1);
      chk_bit("wrap irq", 1'b1, wrap_irq);
      rdc16("count wrapped", `FCT_IDX_COUNT_HI, 16'h0000);
      rdc("wrap flag", `FCT_IDX_FLAGS, 8'h02);
      wr1(`FCT_IDX_FLAGS, 8'h00);
      chk_bit("wrap irq clear", 1'b0, wrap_irq);
   endtask

   task automatic test_clear_a;
      wr1(`FCT_IDX_FLAGS, 8'h01);
      cpu.wr16(`FCT_IDX_COUNT_HI, 16'h000e);
      tick(3);
      rdc16("count cleared", `FCT_IDX_COUNT_HI, 16'h0000);
      rdc("flags clr a", `FCT_IDX_FLAGS, 8'h09);
      wr1(`FCT_IDX_FLAGS, 8'h00);
      cpu.wr16(`FCT_IDX_COUNT_HI, 16'h000f);
      tick(2);
      rdc16("count kept", `FCT_IDX_COUNT_HI, 16'h0011);
      rdc("flags a again", `FCT_IDX_FLAGS, 8'h08);
      wr1(`FCT_IDX_FLAGS, 8'h00);
   endtask

   task automatic test_capture;
      wr1(`FCT_IDX_IRQ_EN, 8'h80);
      cpu.wr16(`FCT_IDX_COUNT_HI, 16'h1234);
      @(posedge aclk);
      capture_strobe <= 1'b1;
      @(posedge aclk);
      capture_strobe <= 1'b0;
      repeat (2) @(posedge aclk);
      chk_bit("capture irq", 1'b1, capture_irq);
      // read-only: a write attempt must leave the captured value
      cpu.wr16(`FCT_IDX_CAP_HI, 16'h5555);
      rdc16("capture", `FCT_IDX_CAP_HI, 16'h1234);
      rdc("capture flag", `FCT_IDX_FLAGS, 8'h80);
      wr1(`FCT_IDX_FLAGS, 8'h00);
      chk_bit("irq off", 1'b0, irq);
   endtask

   initial begin
      failures = 0;
      num_checks = 0;
      aresetn = 1'b0;
      count_tick = 1'b0;
      capture_strobe = 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      test_reset;
      test_match_a;
      test_match_b;
      test_wrap;
      test_clear_a;
      test_capture;
      stop_test;
   end

   // whole run needs a few hundred cycles
   initial begin
      #200000;
      failures++;
      stop_test;
   end
endmodule // tb_free_running_timer_core
